// ---- core/pss_pkg.sv ----
// pss_pkg: constants, register map and carrier structs for the supervisor
// assumes a 20 MHz core clock and a 32-bit AHB-Lite register bus
package pss_pkg;

  // ---------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ            = 20000000;     // core clock rate
  localparam int WARM_FILTER_MS    = 30;           // warm reset debounce
  localparam int EXT_NOMINAL_MS    = 100;          // extension at 1 nF
  localparam int WARM_FILTER_CYC   = CLK_HZ / 1000 * WARM_FILTER_MS;
  localparam int EXT_NOMINAL_CYC   = CLK_HZ / 1000 * EXT_NOMINAL_MS;
  localparam int CNT_W             = 24;           // wide enough for both

  // ---------------------------------------------------------------------
  // register map (printed offsets are indices, byte address = 4 * index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_ID      = 8'h00;      // identity
  localparam logic [7:0] IDX_STATUS  = 8'h01;      // rail status
  localparam logic [7:0] IDX_MASK    = 8'h02;      // interrupt mask
  localparam logic [7:0] IDX_LINCTL  = 8'h03;      // linear regulator control
  localparam logic [7:0] IDX_VSEL    = 8'h04;      // voltage selections (ro)
  localparam logic [7:0] ID_VALUE    = 8'h5a;      // arbitrary identity value
  localparam logic [7:0] MASK_RESET  = 8'hc0;      // mask after lockout
  localparam logic [7:0] UNMAPPED_RD = 8'hff;      // unmapped read value

  // status / mask bit positions
  localparam int BIT_PFAIL = 7;
  localparam int BIT_LBAT  = 6;
  localparam int BIT_CORE  = 5;
  localparam int BIT_BUCK2 = 4;
  localparam int BIT_BUCK3 = 3;
  localparam int BIT_LIN2  = 2;
  localparam int BIT_LIN1  = 1;

  // linear control fields: [0] lin1 off, [1] lin2 off, [2] override,
  // [5:4] lin1 code, [7:6] lin2 code
  localparam int LC_OFF1 = 0;
  localparam int LC_OFF2 = 1;
  localparam int LC_OVR  = 2;

  // voltage codes (millivolts)
  localparam logic [11:0] MV_1V2 = 12'd1200;
  localparam logic [11:0] MV_1V3 = 12'd1300;
  localparam logic [11:0] MV_1V6 = 12'd1600;
  localparam logic [11:0] MV_1V8 = 12'd1800;
  localparam logic [11:0] MV_2V8 = 12'd2800;
  localparam logic [11:0] MV_3V3 = 12'd3300;

  // ---------------------------------------------------------------------
  // carrier structs
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic buck1En;   // core buck enable pin
    logic buck2En;   // second buck enable pin
    logic buck3En;   // third buck enable pin
    logic linEn;     // common regulator enable pin
    logic coreSel;   // core default select pin
    logic buck2Sel;  // second buck default select pin
    logic buck3Sel;  // third buck default select pin
    logic linSelA;   // regulator default select a
    logic linSelB;   // regulator default select b
    logic warmRst;   // warm reset input, active high
  } pss_pins_type;

  typedef struct packed {
    logic uvlo;      // supply undervoltage
    logic overTemp;  // junction overtemperature
    logic backupOk;  // backup rail good
    logic pfail;     // power fail flag
    logic lbat;      // low battery flag
    logic [4:0] lowOut; // rail below regulation: core,b2,b3,l2,l1
  } pss_flags_type;

  typedef struct packed {
    logic [2:0]  buckOn;   // converter run: core,b2,b3
    logic [1:0]  linOn;    // linear run: l2,l1
    logic [11:0] coreMv;   // core target
    logic [11:0] buck2Mv;  // second buck target
    logic [11:0] buck3Mv;  // third buck target
    logic [11:0] lin1Mv;   // first regulator target
    logic [11:0] lin2Mv;   // second regulator target
  } pss_rails_type;

endpackage : pss_pkg

// ---- core/pss_sync.sv ----
// pss_sync: two-flop synchroniser bank for pins and comparator flags
// assumes one clock domain, asynchronous active-high reset
`timescale 1ns/10ps
module pss_sync #(
  parameter int W = 20
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;   // first stage, read only by second
    logic [W-1:0] outp;   // second stage
  } pss_sync_type;

  pss_sync_type state_reg;
  pss_sync_type state_next;

  // next state: shift one stage per edge
  always_comb begin
    state_next      = state_reg;
    state_next.meta = asyncIn;
    state_next.outp = state_reg.meta;
  end

  // register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.outp;

endmodule : pss_sync

// ---- core/pss_supervisor.sv ----
// pss_supervisor: rail enables, defaults, reset and interrupt supervision
// assumes synchronous AHB-Lite master, analog flags arrive asynchronously
//
// What this block does
// - common pin enables both regulators; registers override
// - undervoltage or overtemperature switches every rail off
// - rail dropping out of regulation raises interrupt
// - disabled regulator reports power good
// - lockout keeps outputs off until supply recovers
// - second/third buck default 1.8 or 3.3 V
// - core buck default 1.2 or 1.6 V
// - each buck has its own enable pin
// - warm reset reloads only the core default
// - warm reset input debounced about 30 ms
// - reset low while backup rail not good
// - reset held for capacitor extension time
// - reset output is open drain only
// - debounced warm reset also forces reset
// - core default reloaded under any reset condition
// - regulator default pins latched at power-up
// - software may rewrite regulator voltages
// - power-up: interrupt low until enabled rails regulate
// - rail loss drives interrupt low, sets status
// - status read releases interrupt, status stays
// - mask suppresses sources; rails unmasked after reset
// - status bits 7..1 pfail,lbat,bucks,regulators
// - mask resets to c0 on lockout
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module pss_supervisor #(
  parameter int WARM_CYC = pss_pkg::WARM_FILTER_CYC, // debounce length
  parameter int EXT_CYC  = pss_pkg::EXT_NOMINAL_CYC   // reset extension
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // pins and analog flags
  input  wire pss_pkg::pss_pins_type  pins,
  input  wire pss_pkg::pss_flags_type flags,
  // rail control
  output pss_pkg::pss_rails_type      rails,
  // open-drain outputs: input level, drive value, enable (low = drive)
  input  wire logic                   resetPinIn,
  output logic                        resetPinOut,
  output logic                        resetPinOe_n,
  input  wire logic                   intPinIn,
  output logic                        intPinOut,
  output logic                        intPinOe_n
);

  // ---------------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------------
  localparam int SW = $bits(pss_pkg::pss_pins_type)
                    + $bits(pss_pkg::pss_flags_type);

  logic [SW-1:0]          syncBus;   // synchronised pins and flags
  pss_pkg::pss_pins_type  sPins;     // pins in clock domain
  pss_pkg::pss_flags_type sFlags;    // flags in clock domain

  pss_sync #(.W(SW)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({pins, flags}),
    .syncOut  (syncBus)
  );

  assign {sPins, sFlags} = syncBus;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  localparam int CNT_W = pss_pkg::CNT_W;  // counter width, before its use

  typedef enum logic [1:0] {
    RS_HOLD = 2'b00,   // reset output low, waiting for cause to end
    RS_EXT  = 2'b01,   // extension running
    RS_RUN  = 2'b11    // reset released
  } pss_rst_type;

  typedef struct packed {
    pss_rst_type      rstSt;     // reset sequencer
    logic [CNT_W-1:0] extCnt;    // extension counter
    logic [CNT_W-1:0] dbCnt;     // debounce counter
    logic             warmDb;    // debounced warm reset
    logic             latched;   // regulator defaults captured
    logic [1:0]       linDef;    // captured default pin code
    logic [7:0]       mask;      // interrupt mask
    logic [7:0]       linCtl;    // linear regulator control
    logic             released;  // interrupt released by status read
    logic [7:0]       prevSrc;   // sources seen last cycle
    logic             aPhase;    // data phase pending
    logic             aWrite;    // pending is a write
    logic [7:0]       aIdx;      // pending register index
    logic [31:0]      rdata;     // read data
    logic             intLow;    // interrupt pin pulled low
  } pss_state_type;

  pss_state_type state_reg;
  pss_state_type state_next;

  // ---------------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------------
  logic       shutdown;    // lockout or overtemperature
  logic [2:0] buckOn;      // converter run
  logic [1:0] linOn;       // linear run
  logic [7:0] status;      // rail status word
  logic [7:0] srcActive;   // unmasked active sources
  logic       rstActive;   // reset output asserted
  logic       coreReload;  // core default reload condition

  assign shutdown  = sFlags.uvlo | sFlags.overTemp;
  // each buck on its own pin, all off under shutdown
  assign buckOn    = shutdown ? 3'b000
                   : {sPins.buck1En, sPins.buck2En, sPins.buck3En};
  // common pin enables both, software may switch each off
  assign linOn[1]  = ~shutdown & sPins.linEn
                   & ~state_reg.linCtl[pss_pkg::LC_OFF2];
  assign linOn[0]  = ~shutdown & sPins.linEn
                   & ~state_reg.linCtl[pss_pkg::LC_OFF1];

  // status: a disabled rail reads as good
  assign status = {sFlags.pfail, sFlags.lbat,
                   sFlags.lowOut[4:0] & {buckOn, linOn}, 1'b0};
  assign srcActive  = status & ~state_reg.mask;
  assign rstActive  = state_reg.rstSt != RS_RUN;
  assign coreReload = state_reg.warmDb | ~sFlags.backupOk
                    | sFlags.uvlo | rstActive;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic       takeAddr;  // address phase accepted
    logic       wr;        // data phase write this cycle
    logic [7:0] rdIdx;     // index for read decode
    takeAddr   = 1'b0;
    wr         = 1'b0;
    rdIdx      = 8'h00;
    state_next = state_reg;

    // warm reset debounce: level must hold for the whole filter time
    if (sPins.warmRst == state_reg.warmDb) begin
      state_next.dbCnt = '0;
    end else if (state_reg.dbCnt >= CNT_W'(WARM_CYC - 1)) begin
      state_next.dbCnt  = '0;
      state_next.warmDb = sPins.warmRst;
    end else begin
      state_next.dbCnt = state_reg.dbCnt + 1'b1;
    end

    // reset sequencer
    unique case (state_reg.rstSt)
      RS_HOLD: begin
        // hold low while backup rail bad or warm reset active
        state_next.extCnt = '0;
        if (sFlags.backupOk && !state_reg.warmDb) begin
          state_next.rstSt = RS_EXT;
        end
      end
      RS_EXT: begin
        if (!sFlags.backupOk || state_reg.warmDb) begin
          state_next.rstSt = RS_HOLD;
        end else if (state_reg.extCnt >= CNT_W'(EXT_CYC - 1)) begin
          state_next.rstSt = RS_RUN;
        end else begin
          state_next.extCnt = state_reg.extCnt + 1'b1;
        end
      end
      RS_RUN: begin
        if (!sFlags.backupOk || state_reg.warmDb) begin
          state_next.rstSt = RS_HOLD;
        end
      end
      default: state_next.rstSt = RS_HOLD;
    endcase

    // follow default pins through power-up reset, freeze on first release
    if (!state_reg.latched) begin
      state_next.latched = state_reg.rstSt == RS_RUN;
      state_next.linDef  = {sPins.linSelB, sPins.linSelA};
    end

    // lockout reloads mask and linear control; other registers kept
    if (sFlags.uvlo) begin
      state_next.mask   = pss_pkg::MASK_RESET;
      state_next.linCtl = 8'h00;
    end

    // bus data phase
    if (state_reg.aPhase && state_reg.aWrite) begin
      wr = 1'b1;
    end
    if (wr && !sFlags.uvlo) begin
      unique case (state_reg.aIdx)
        pss_pkg::IDX_MASK:   state_next.mask   = {hwdata[7:1], 1'b0};
        pss_pkg::IDX_LINCTL: state_next.linCtl = hwdata[7:0];
        default: ;
      endcase
    end

    // bus address phase
    takeAddr = hsel & hready & htrans[1];
    state_next.aPhase = takeAddr;
    state_next.aWrite = hwrite;
    state_next.aIdx   = haddr[9:2];
    rdIdx             = haddr[9:2];
    if (takeAddr && !hwrite) begin
      unique case (rdIdx)
        pss_pkg::IDX_ID:     state_next.rdata = {24'h0, pss_pkg::ID_VALUE};
        pss_pkg::IDX_STATUS: state_next.rdata = {24'h0, status};
        pss_pkg::IDX_MASK:   state_next.rdata = {24'h0, state_reg.mask};
        pss_pkg::IDX_LINCTL: state_next.rdata = {24'h0, state_reg.linCtl};
        pss_pkg::IDX_VSEL:   state_next.rdata = {24'h0, 4'h0,
                               sPins.coreSel, sPins.buck2Sel,
                               state_reg.linDef};
        default: state_next.rdata = {24'h0, pss_pkg::UNMAPPED_RD};
      endcase
    end

    // interrupt: new source rearms, status read while low releases
    if (srcActive == 8'h00) begin
      state_next.released = 1'b0;
    end else if ((srcActive & ~state_reg.prevSrc) != 8'h00) begin
      state_next.released = 1'b0;
    end else if (takeAddr && !hwrite && rdIdx == pss_pkg::IDX_STATUS
                 && state_reg.intLow) begin
      state_next.released = 1'b1;
    end
    state_next.prevSrc = srcActive;
    state_next.intLow  = (srcActive != 8'h00) && !state_next.released;
  end

  // register, constants only under reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg        <= '0;
      state_reg.rstSt  <= RS_HOLD;
      state_reg.mask   <= pss_pkg::MASK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------
  // rail targets
  // ---------------------------------------------------------------------
  // core voltage register; reloads from its pin under any reset cause
  logic [11:0] coreMv_reg;
  logic [11:0] coreMv_next;
  logic [11:0] coreDefault;
  logic [11:0] lin1Def;
  logic [11:0] lin2Def;
  logic [11:0] lin1Mv;
  logic [11:0] lin2Mv;

  assign coreDefault = sPins.coreSel ? pss_pkg::MV_1V6
                                     : pss_pkg::MV_1V2;
  assign coreMv_next = coreReload ? coreDefault : coreMv_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coreMv_reg <= pss_pkg::MV_1V2;
    end else begin
      coreMv_reg <= coreMv_next;
    end
  end

  // regulator default table
  always_comb begin
    unique case (state_reg.linDef)
      2'b00: begin
        lin1Def = pss_pkg::MV_1V3;
        lin2Def = pss_pkg::MV_3V3;
      end
      2'b01: begin
        lin1Def = pss_pkg::MV_2V8;
        lin2Def = pss_pkg::MV_3V3;
      end
      2'b10: begin
        lin1Def = pss_pkg::MV_1V3;
        lin2Def = pss_pkg::MV_1V8;
      end
      2'b11: begin
        lin1Def = pss_pkg::MV_1V8;
        lin2Def = pss_pkg::MV_3V3;
      end
    endcase
  end

  // software code overrides latched default
  function automatic logic [11:0] codeMv(input logic [1:0] c);
    unique case (c)
      2'b00: codeMv = pss_pkg::MV_1V3;
      2'b01: codeMv = pss_pkg::MV_1V8;
      2'b10: codeMv = pss_pkg::MV_2V8;
      2'b11: codeMv = pss_pkg::MV_3V3;
    endcase
  endfunction : codeMv

  assign lin1Mv = state_reg.linCtl[pss_pkg::LC_OVR]
                ? codeMv(state_reg.linCtl[5:4]) : lin1Def;
  assign lin2Mv = state_reg.linCtl[pss_pkg::LC_OVR]
                ? codeMv(state_reg.linCtl[7:6]) : lin2Def;

  // outputs
  always_comb begin
    rails         = '0;
    rails.buckOn  = buckOn;
    rails.linOn   = linOn;
    rails.coreMv  = coreMv_reg;
    rails.buck2Mv = sPins.buck2Sel ? pss_pkg::MV_3V3 : pss_pkg::MV_1V8;
    rails.buck3Mv = sPins.buck3Sel ? pss_pkg::MV_3V3
                                   : pss_pkg::MV_1V8;
    rails.lin1Mv  = lin1Mv;
    rails.lin2Mv  = lin2Mv;
  end

  // ---------------------------------------------------------------------
  // pins and bus answer
  // ---------------------------------------------------------------------
  assign resetPinOut  = 1'b0;
  assign resetPinOe_n = ~rstActive;
  assign intPinOut    = 1'b0;
  assign intPinOe_n   = ~state_reg.intLow;
  assign hrdata       = state_reg.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;

endmodule : pss_supervisor

// ---- verif/pss_chk.sv ----
// pss_chk: port-level assertions for the supervisor top
// assumes binding into pss_supervisor
`timescale 1ns/10ps
module pss_chk #(
  parameter int WARM_CYC = 8,
  parameter int EXT_CYC  = 16
) (
  input logic                   core_clk,
  input logic                   rst,
  input logic                   hreadyout,
  input logic                   hresp,
  input pss_pkg::pss_pins_type  pins,
  input pss_pkg::pss_flags_type flags,
  input pss_pkg::pss_rails_type rails,
  input logic                   resetPinOut,
  input logic                   resetPinOe_n,
  input logic                   intPinOut,
  input logic                   intPinOe_n
);
  // ----------
  // helper logic
  // ----------
  int   okCnt;   // run with no reset cause
  int   warmCnt; // warm reset run
  logic src;     // some interrupt source present
  assign src = (|flags.lowOut) | flags.pfail | flags.lbat;
  // run lengths of the reset causes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      okCnt   <= 0;
      warmCnt <= 0;
    end else begin
      okCnt   <= (flags.backupOk && !pins.warmRst) ? okCnt + 1 : 0;
      warmCnt <= pins.warmRst ? warmCnt + 1 : 0;
    end
  end
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_lockout_off: assert property (
    (flags.uvlo || flags.overTemp)[*3] |->
      rails.buckOn == 3'h0 && rails.linOn == 2'h0)
    else $error("rail running in lockout");
  a_buck_pins: assert property (
    (!flags.uvlo && !flags.overTemp && $stable(pins))[*3] |->
      rails.buckOn == {pins.buck1En, pins.buck2En, pins.buck3En})
    else $error("converter run off its pin");
  a_buck_sel: assert property (
    $stable(pins)[*3] |-> rails.buck3Mv ==
      (pins.buck3Sel ? pss_pkg::MV_3V3 : pss_pkg::MV_1V8))
    else $error("third converter default wrong");
  a_core_reload: assert property (
    (!resetPinOe_n && $stable(pins.coreSel))[*5] |-> rails.coreMv ==
      (pins.coreSel ? pss_pkg::MV_1V6 : pss_pkg::MV_1V2))
    else $error("core default not reloaded");
  a_hold_backup: assert property (
    (!flags.backupOk)[*3] |=> !resetPinOe_n)
    else $error("reset released, backup low");
  a_open_drain: assert property (
    resetPinOut == 1'b0 && intPinOut == 1'b0)
    else $error("open drain pin driven high");
  a_ext_len: assert property (
    $rose(resetPinOe_n) |-> okCnt >= EXT_CYC)
    else $error("reset extension too short");
  a_warm_len: assert property (
    $fell(resetPinOe_n) && flags.backupOk && $past(flags.backupOk, 4)
      |-> warmCnt >= WARM_CYC)
    else $error("warm reset acted before debounce");
  a_int_cause: assert property (
    !intPinOe_n |-> $past(src) || $past(src, 2) || $past(src, 3)
      || $past(src, 4))
    else $error("interrupt low with no source");
  a_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("bus answer not OKAY");
endmodule : pss_chk

bind pss_supervisor pss_chk #(.WARM_CYC(WARM_CYC), .EXT_CYC(EXT_CYC))
  i_pss_chk (.core_clk, .rst, .hreadyout, .hresp, .pins, .flags, .rails,
  .resetPinOut, .resetPinOe_n, .intPinOut, .intPinOe_n);

// ---- verif/pss_host_model.sv ----
// pss_host_model: host side of the reset and interrupt wires
// assumes external pull-ups; design pins are open drain
`timescale 1ns/10ps
module pss_host_model (
  input  logic resetPinOut,
  input  logic resetPinOe_n,
  input  logic intPinOut,
  input  logic intPinOe_n,
  output logic resetLine,
  output logic intLine
);
  // pull-ups lift a released wire high
  assign resetLine = resetPinOe_n ? 1'b1 : resetPinOut;
  assign intLine   = intPinOe_n ? 1'b1 : intPinOut;
endmodule : pss_host_model

// ---- verif/pmic_supervisor_reset_int_tb_top.sv ----
// pmic_supervisor_reset_int_tb_top: self-checking bench, integer model
// assumes package, design and host model compiled first
`timescale 1ns/10ps
module pmic_supervisor_reset_int_tb_top;
  // ----------
  // signals and model state
  // ----------
  localparam int WC = 8;               // short debounce count
  localparam int EC = 16;              // short extension count
  logic                   core_clk = 1'b0;
  logic                   rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0]            haddr, hwdata, hrdata;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  wire                    hready;
  pss_pkg::pss_pins_type  pn;          // pin levels
  pss_pkg::pss_flags_type fl;          // analog flags
  pss_pkg::pss_rails_type rl;          // rail controls
  wire                    resetLine, intLine;
  logic                   rOut, rOe_n, iOut, iOe_n;
  int                     failures, n_tests, maskM, linM, dIdx;
  logic [31:0]            r;
  logic [11:0] mv[4] = '{pss_pkg::MV_1V3, pss_pkg::MV_1V8,
                         pss_pkg::MV_2V8, pss_pkg::MV_3V3};
  logic [11:0] d1[4] = '{pss_pkg::MV_1V3, pss_pkg::MV_2V8,
                         pss_pkg::MV_1V3, pss_pkg::MV_1V8};
  logic [11:0] d2[4] = '{pss_pkg::MV_3V3, pss_pkg::MV_3V3,
                         pss_pkg::MV_1V8, pss_pkg::MV_3V3};
  assign hready = hreadyout;
  always #25 core_clk = ~core_clk;     // 50 ns period
  pss_supervisor #(.WARM_CYC(WC), .EXT_CYC(EC)) i_pss_supervisor (
    .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .pins(pn), .flags(fl), .rails(rl),
    .resetPinIn(resetLine), .resetPinOut(rOut), .resetPinOe_n(rOe_n),
    .intPinIn(intLine), .intPinOut(iOut), .intPinOe_n(iOe_n));
  pss_host_model i_pss_host_model (.resetPinOut(rOut),
    .resetPinOe_n(rOe_n), .intPinOut(iOut), .intPinOe_n(iOe_n),
    .resetLine(resetLine), .intLine(intLine));
  // ----------
  // tasks
  // ----------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
  endtask : step
  // bounded wait for hready (rs 0) or the reset wire (rs 1) to reach v;
  // a nonzero hi also checks the edge count against lo..hi
  task automatic waitOn(input bit rs, input logic v, input int lo, hi);
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while ((rs ? resetLine : hready) !== v && k < 300);
    if (k >= 300) begin
      failures++;
      conclude();
    end
    if (hi > 0) chk(k >= lo && k <= hi, 1);
  endtask : waitOn
  // single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    waitOn(1'b0, 1'b1, 0, 0);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitOn(1'b0, 1'b1, 0, 0);
    rd = hrdata;
  endtask : xfer
  // write; lockout refuses it
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    xfer(1'b1, idx, v, r);
    if (fl.uvlo !== 1'b1 && idx == pss_pkg::IDX_MASK) maskM = v & 8'hfe;
    if (fl.uvlo !== 1'b1 && idx == pss_pkg::IDX_LINCTL) linM = v;
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0, r);
    chk(r, e);
  endtask : rd
  // rails and status against the model
  task automatic chkRails();
    logic [2:0] bon;
    logic [1:0] lon;
    bon = (fl.uvlo | fl.overTemp) ? 3'h0 : pn[9:7];
    lon = (fl.uvlo | fl.overTemp) ? 2'h0 :
          {pn.linEn & ~linM[1], pn.linEn & ~linM[0]};
    chk(rl.buckOn, bon);
    chk(rl.linOn, lon);
    chk({rl.buck2Mv, rl.buck3Mv}, {mv[{pn.buck2Sel, 1'b1}],
        mv[{pn.buck3Sel, 1'b1}]});
    chk(rl.lin1Mv, linM[2] ? mv[linM[5:4]] : d1[dIdx]);
    chk(rl.lin2Mv, linM[2] ? mv[linM[7:6]] : d2[dIdx]);
    rd(pss_pkg::IDX_STATUS, {fl.pfail, fl.lbat, fl.lowOut[4:2] & bon,
       fl.lowOut[1:0] & lon, 1'b0});
  endtask : chkRails
  // ----------
  // main sequence
  // ----------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    pn = '0;
    fl = '0;
    fl.backupOk = 1'b1;
    {failures, n_tests, linM} = '0;
    void'($urandom(32'hbb97));
    // reset per default code
    for (int c = 0; c < 4; c++) begin
      rst <= 1'b1;
      {pn.linSelB, pn.linSelA} <= c[1:0];
      step(12);
      rst <= 1'b0;
      {dIdx, maskM, linM} = {c, 32'hc0, 32'h0};
      waitOn(1'b1, 1'b1, EC, EC + 5);
      rd(pss_pkg::IDX_ID, pss_pkg::ID_VALUE);
      rd(pss_pkg::IDX_VSEL, c);
      rd(pss_pkg::IDX_MASK, 32'hc0);
      rd(8'h3f, 32'hff);
      chkRails();
    end
    // random pins, flags and controls
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      pn <= {r[9:6], pn.coreSel, r[4:1], 1'b0};
      fl.lowOut <= r[14:10];
      {fl.pfail, fl.lbat} <= r[16:15];
      wr(pss_pkg::IDX_LINCTL, {24'h0, r[23:16] & 8'hf7});
      wr(pss_pkg::IDX_MASK, {24'h0, r[31:24]});
      rd(pss_pkg::IDX_MASK, maskM);
      step(2);
      chkRails();
    end
    // power-up interrupt
    {fl.pfail, fl.lbat} <= 2'b00;
    fl.lowOut <= 5'h1f;
    pn <= {4'hf, pn.coreSel, 5'h0};
    wr(pss_pkg::IDX_LINCTL, 32'h0);
    wr(pss_pkg::IDX_MASK, 32'hc0);
    step(5);
    chk(intLine, 0);
    fl.lowOut <= 5'h01;
    step(5);
    chk(intLine, 0);
    fl.lowOut <= 5'h00;
    step(5);
    chk(intLine, 1);
    fl.lowOut <= 5'h04;
    step(5);
    chk(intLine, 0);
    rd(pss_pkg::IDX_STATUS, 32'h08);
    step(2);
    chk(intLine, 1);
    rd(pss_pkg::IDX_STATUS, 32'h08);
    fl.lowOut <= 5'h00;
    step(5);
    chk(intLine, 1);
    wr(pss_pkg::IDX_MASK, 32'hc8);
    fl.lowOut <= 5'h04;
    fl.pfail <= 1'b1;
    step(5);
    chk(intLine, 1);
    fl.lowOut <= 5'h14;
    step(5);
    chk(intLine, 0);
    // lockout and overtemperature
    {fl.lowOut, fl.pfail} <= '0;
    wr(pss_pkg::IDX_LINCTL, 32'h74);
    fl.uvlo <= 1'b1;
    {maskM, linM} = {32'hc0, 32'h0};
    step(4);
    wr(pss_pkg::IDX_MASK, 32'h0);
    rd(pss_pkg::IDX_MASK, 32'hc0);
    chkRails();
    fl.uvlo <= 1'b0;
    fl.overTemp <= 1'b1;
    step(4);
    chkRails();
    fl.overTemp <= 1'b0;
    step(4);
    chkRails();
    // core default reload
    pn.coreSel <= 1'b1;
    step(5);
    chk(rl.coreMv, pss_pkg::MV_1V2);
    pn.warmRst <= 1'b1;
    step(WC - 3);
    pn.warmRst <= 1'b0;
    step(6);
    chk(resetLine, 1);
    wr(pss_pkg::IDX_MASK, 32'hc4);
    pn.warmRst <= 1'b1;
    waitOn(1'b1, 1'b0, WC, WC + 5);
    step(2);
    chk(rl.coreMv, pss_pkg::MV_1V6);
    pn.warmRst <= 1'b0;
    waitOn(1'b1, 1'b1, EC + WC, EC + WC + 6);
    rd(pss_pkg::IDX_MASK, 32'hc4);
    // backup rail loss
    pn.coreSel <= 1'b0;
    fl.backupOk <= 1'b0;
    step(6);
    chk({resetLine, rl.coreMv}, {1'b0, pss_pkg::MV_1V2});
    fl.backupOk <= 1'b1;
    waitOn(1'b1, 1'b1, EC, EC + 5);
    conclude();
  end
endmodule : pmic_supervisor_reset_int_tb_top
